// ==== core/ccd_cycle_control.sv ====
// Purpose: cache select/write/tag control and shared row strobe sequencing for page dram
// Assumes: cycle_start is a one-cycle pulse, accepted only while cycle_idle is high;
//          tag_match is synchronous to sys_clk
// Notes:   write-through cache; only cacheable read misses refill and rewrite the tag
//
// How it works
// RULE_01: match valid held low during tag update
// RULE_02: sram select high except during update
// RULE_03: cache byte writes follow active byte enables
// RULE_04: tag write pulses in the update cycle
// RULE_05: pipeline request driven while tag updates
// RULE_06: tag buffer open only during update
// RULE_07: direction low cache-to-cpu, high cpu-to-cache
// RULE_08: buffer enables gated per byte enable
// RULE_09: page mode keeps row open on row hit
// RULE_10: row stays open across banks, same row
// RULE_11: normal mode precharges before every access
// RULE_12: select low gives row, high column
// RULE_13: one row strobe shared by all banks
// RULE_14: match valid marks when tag match sampled
// RULE_15: hit qualified by cacheable memory cycle
// RULE_16: one column strobe per bank, released after
// RULE_17: page mode setting steers row strobe
// RULE_18: row select during row strobe, column before strobe

`timescale 1ns/1ps

module ccd_cycle_control
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,

    // processor or dma cycle request
    input  wire logic        cycle_start,
    input  wire logic        cycle_memory,
    input  wire logic        cycle_write,
    input  wire logic        cycle_cacheable,
    input  wire logic [3:0]  cycle_byte_en,
    input  wire logic [9:0]  cycle_row,
    input  wire logic [1:0]  cycle_bank,
    output logic             cycle_idle,
    output logic             memory_ready,

    // configuration
    input  wire logic        page_mode_cfg,

    // tag subsystem
    input  wire logic        tag_match,
    output logic             match_valid_out,
    output logic             tag_store_write,
    output logic             tag_buffer_drive,
    output logic             pipeline_request,

    // data cache sram and buffers
    output logic             data_sram_select,
    output logic [3:0]       data_sram_byte_write,
    output logic             cache_buffer_direction,
    output logic [3:0]       cache_buffer_byte_enable,

    // dram strobes
    output logic             row_strobe,
    output logic             row_column_select,
    output logic [3:0]       column_strobe
);

    ccd_pkg::ccd_state_e        state_reg;
    ccd_pkg::ccd_state_e        state_next;
    logic [ccd_pkg::WAIT_W-1:0] wait_reg;
    logic [ccd_pkg::WAIT_W-1:0] wait_next;
    logic                       write_reg;
    logic                       memory_reg;
    logic                       cacheable_reg;
    logic                       page_mode_reg;
    logic [3:0]                 byte_en_reg;
    logic [ccd_pkg::ROW_W-1:0]  row_reg;
    logic [1:0]                 bank_reg;
    logic                       refill_reg;
    logic                       row_open_reg;
    logic [ccd_pkg::ROW_W-1:0]  open_row_reg;
    logic                       ras_reg;
    logic                       mux_reg;
    logic                       qualified_hit;
    logic                       wait_over;

    // gate the byte lanes of the current cycle with a condition
    function automatic logic [3:0] lanes_if(input logic [3:0] en, input logic cond);
        lanes_if = cond ? en : ccd_pkg::LANE_NONE;
    endfunction

    // timed wait count, loaded on entry to a timed state
    function automatic logic [ccd_pkg::WAIT_W-1:0] cyc(input int n);
        cyc = ccd_pkg::WAIT_W'(n - 1);
    endfunction

    // RULE_15: cacheable memory qualification
    assign qualified_hit = tag_match & cacheable_reg & memory_reg;
    assign wait_over     = (wait_reg == '0);

    // capture the cycle attributes; latching the page setting per access keeps
    // a mid-access change of the strap from tearing the strobe sequence
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            write_reg     <= 1'b0;
            memory_reg    <= 1'b0;
            cacheable_reg <= 1'b0;
            page_mode_reg <= 1'b0;
            byte_en_reg   <= ccd_pkg::LANE_NONE;
            row_reg       <= ccd_pkg::ROW_RESET;
            bank_reg      <= 2'h0;
        end
        else if (cycle_start && (state_reg == ccd_pkg::ST_IDLE))
        begin
            write_reg     <= cycle_write;
            memory_reg    <= cycle_memory;
            cacheable_reg <= cycle_cacheable;
            // RULE_17: mode held per access
            page_mode_reg <= page_mode_cfg;
            byte_en_reg   <= cycle_byte_en;
            row_reg       <= cycle_row;
            bank_reg      <= cycle_bank;
        end
    end

    // refill marker: set in lookup on a cacheable read miss
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            refill_reg <= 1'b0;
        else if (state_reg == ccd_pkg::ST_LOOKUP)
            refill_reg <= cacheable_reg & memory_reg & ~write_reg & ~tag_match;
    end

    // sequencer next state
    always_comb
    begin
        state_next = state_reg;
        wait_next  = wait_over ? wait_reg : wait_reg - 1'b1;
        case (state_reg)
            ccd_pkg::ST_IDLE:
            begin
                if (cycle_start)
                    state_next = ccd_pkg::ST_LOOKUP;
            end
            ccd_pkg::ST_LOOKUP:
            begin
                if (!memory_reg || (qualified_hit && !write_reg))
                    state_next = ccd_pkg::ST_IDLE;  // read hit ends on external ready
                // RULE_09: same open row goes straight to column
                // RULE_10: bank ignored in the row compare
                else if (page_mode_reg && row_open_reg && (open_row_reg == row_reg))
                begin
                    state_next = ccd_pkg::ST_COL;
                    wait_next  = cyc(ccd_pkg::COLUMN_CYC);
                end
                // RULE_11: precharge before the access
                else
                begin
                    state_next = ccd_pkg::ST_PRE;
                    wait_next  = cyc(ccd_pkg::PRECHARGE_CYC);
                end
            end
            ccd_pkg::ST_PRE:
            begin
                if (wait_over)
                begin
                    state_next = ccd_pkg::ST_ROW;
                    wait_next  = cyc(ccd_pkg::ROW_HOLD_CYC);
                end
            end
            ccd_pkg::ST_ROW:
            begin
                if (wait_over)
                    state_next = ccd_pkg::ST_MUX;
            end
            ccd_pkg::ST_MUX:
            begin
                state_next = ccd_pkg::ST_COL;
                wait_next  = cyc(ccd_pkg::COLUMN_CYC);
            end
            ccd_pkg::ST_COL:
            begin
                if (wait_over)
                    state_next = refill_reg ? ccd_pkg::ST_UPDATE : ccd_pkg::ST_DONE;
            end
            ccd_pkg::ST_UPDATE:
                state_next = ccd_pkg::ST_DONE;
            ccd_pkg::ST_DONE:
                state_next = ccd_pkg::ST_IDLE;
            default:
                state_next = ccd_pkg::ST_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_reg <= ccd_pkg::ST_IDLE;
            wait_reg  <= '0;
        end
        else
        begin
            state_reg <= state_next;
            wait_reg  <= wait_next;
        end
    end

    // RULE_13: single row strobe for every bank
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            ras_reg <= 1'b0;
        else if (state_next == ccd_pkg::ST_PRE)
            ras_reg <= 1'b0;
        else if (state_next == ccd_pkg::ST_ROW)
            ras_reg <= 1'b1;
        // RULE_11: normal mode closes the row
        else if ((state_next == ccd_pkg::ST_DONE) && !page_mode_reg)
            ras_reg <= 1'b0;
    end

    // open row tracking, only meaningful while the row strobe is held
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            row_open_reg <= 1'b0;
            open_row_reg <= ccd_pkg::ROW_RESET;
        end
        else if (state_next == ccd_pkg::ST_ROW)
        begin
            row_open_reg <= 1'b1;
            open_row_reg <= row_reg;
        end
        else if (state_next == ccd_pkg::ST_PRE)
            row_open_reg <= 1'b0;
        else if ((state_next == ccd_pkg::ST_DONE) && !page_mode_reg)
            row_open_reg <= 1'b0;
    end

    // RULE_18: row address under strobe, column set a cycle before strobe
    // RULE_12: select levels for row and column
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            mux_reg <= ccd_pkg::SEL_ROW;
        else if ((state_next == ccd_pkg::ST_PRE) || (state_next == ccd_pkg::ST_ROW))
            mux_reg <= ccd_pkg::SEL_ROW;
        else if (state_next == ccd_pkg::ST_MUX)
            mux_reg <= ccd_pkg::SEL_COLUMN;
        else if ((state_next == ccd_pkg::ST_COL) && (state_reg == ccd_pkg::ST_LOOKUP))
            mux_reg <= ccd_pkg::SEL_COLUMN; // page hit: select was still at column
    end

    assign row_strobe        = ras_reg;
    assign row_column_select = mux_reg;

    // RULE_16: only the accessed bank strobes, all released outside column
    always_comb
    begin
        column_strobe = ccd_pkg::LANE_NONE;
        if (state_reg == ccd_pkg::ST_COL)
            column_strobe[bank_reg] = 1'b1;
    end

    // RULE_14: sampled only in lookup of a cacheable memory read, so that
    // RULE_01: never valid in update; uncached or write cycles get no early ready
    assign match_valid_out = (state_reg == ccd_pkg::ST_LOOKUP) && memory_reg && cacheable_reg
                             && !write_reg;

    // RULE_02: select low only while updating
    assign data_sram_select = (state_reg != ccd_pkg::ST_UPDATE);

    // RULE_04: tag rewrite strobe
    assign tag_store_write  = (state_reg == ccd_pkg::ST_UPDATE);
    // RULE_06: tag buffer only in update
    assign tag_buffer_drive = (state_reg == ccd_pkg::ST_UPDATE);
    // RULE_05: pipeline request raised in the update cycle, with the tag write
    assign pipeline_request = (state_reg == ccd_pkg::ST_UPDATE);

    // RULE_03: byte writes for write hits and refill
    assign data_sram_byte_write = lanes_if(byte_en_reg,
        ((state_reg == ccd_pkg::ST_LOOKUP) && qualified_hit && write_reg) ||
        (state_reg == ccd_pkg::ST_UPDATE));

    // RULE_07: write data and refill flow cpu side to cache
    assign cache_buffer_direction = (write_reg || (state_reg == ccd_pkg::ST_UPDATE))
                                    ? ccd_pkg::DIR_CPU_TO_CACHE : ccd_pkg::DIR_CACHE_TO_CPU;

    // RULE_08: buffer enables gated by byte enables
    assign cache_buffer_byte_enable = lanes_if(byte_en_reg,
        ((state_reg == ccd_pkg::ST_LOOKUP) && qualified_hit) ||
        (state_reg == ccd_pkg::ST_UPDATE));

    // dram and non-memory cycles finish here; read hits finish on external ready
    assign memory_ready = (state_reg == ccd_pkg::ST_DONE) ||
                          ((state_reg == ccd_pkg::ST_LOOKUP) && !memory_reg);
    assign cycle_idle   = (state_reg == ccd_pkg::ST_IDLE);

endmodule

// ==== core/ccd_pkg.sv ====
// Purpose: shared constants for the cache and page-mode dram cycle control block
// Assumes: 40 MHz sys_clk, one cycle per processor bus request
// Notes:   dram timing figures are plain defaults, not taken from any part

package ccd_pkg;

    // clock and dram timing, figures in ns
    localparam int CLK_PERIOD_NS    = 25;
    localparam int T_PRECHARGE_NS   = 50;   // least row strobe low time
    localparam int T_ROW_HOLD_NS    = 25;   // least row address hold after strobe
    localparam int T_COLUMN_NS      = 50;   // least column strobe width

    // least times round up to whole cycles, never below one
    localparam int PRECHARGE_CYC = (T_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_HOLD_CYC  = (T_ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COLUMN_CYC    = (T_COLUMN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // widths
    localparam int BYTE_LANES = 4;
    localparam int BANKS      = 4;
    localparam int ROW_W      = 10;
    localparam int WAIT_W     = 3;

    // values after reset
    localparam logic [ROW_W-1:0] ROW_RESET = 10'h000;
    localparam logic [3:0]       LANE_NONE = 4'h0;

    // row/column select levels
    localparam logic SEL_ROW    = 1'b0;
    localparam logic SEL_COLUMN = 1'b1;

    // cache buffer direction levels
    localparam logic DIR_CACHE_TO_CPU = 1'b0;
    localparam logic DIR_CPU_TO_CACHE = 1'b1;

    // cycle sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_LOOKUP = 8'h02,
        ST_PRE    = 8'h04,
        ST_ROW    = 8'h08,
        ST_MUX    = 8'h10,
        ST_COL    = 8'h20,
        ST_UPDATE = 8'h40,
        ST_DONE   = 8'h80
    } ccd_state_e;

endpackage

// ==== bench/ccd_tag_model.sv ====
// Purpose: one-entry tag store standing beside the cycle control block
// Assumes: address latched at each accepted request
// Notes:   compare is combinational, so a rewritten tag matches late
`timescale 1ns/1ps
module ccd_tag_model
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // request snoop and tag write
    input  wire logic       cycle_start,
    input  wire logic       cycle_idle,
    input  wire logic [9:0] cycle_row,
    input  wire logic       tag_store_write,
    // match back to the block
    output logic            tag_match
);
    logic [9:0] addr_reg;
    logic [9:0] tag_reg;
    logic       valid_reg;

    // address latch, updated only on an accepted request
    always_ff @(posedge sys_clk)
    begin
        if (cycle_start && cycle_idle)
            addr_reg <= cycle_row;
    end

    // tag write stores the latched address
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            valid_reg <= 1'b0;
        else if (tag_store_write)
        begin
            valid_reg <= 1'b1;
            tag_reg   <= addr_reg;
        end
    end

    assign tag_match = valid_reg && (tag_reg == addr_reg);
endmodule

// ==== bench/ccd_cycle_control_chk.sv ====
// Purpose: port assertions for the cycle control block
// Assumes: one sys_clk domain, srst synchronous
// Notes:   byte enables are captured here at each accepted request
`timescale 1ns/1ps
module ccd_cycle_control_chk
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       srst,
    // request side
    input wire logic       cycle_start,
    input wire logic       cycle_idle,
    input wire logic [3:0] cycle_byte_en,
    // watched outputs
    input wire logic       match_valid_out,
    input wire logic       tag_store_write,
    input wire logic       tag_buffer_drive,
    input wire logic       pipeline_request,
    input wire logic       data_sram_select,
    input wire logic [3:0] data_sram_byte_write,
    input wire logic       cache_buffer_direction,
    input wire logic [3:0] cache_buffer_byte_enable,
    input wire logic       row_strobe,
    input wire logic       row_column_select,
    input wire logic [3:0] column_strobe
);
    logic [3:0] be_reg;

    // lanes outside the accepted byte enables must stay quiet
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            be_reg <= 4'h0;
        else if (cycle_start && cycle_idle)
            be_reg <= cycle_byte_en;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // row opened with the row address on the multiplexers
    sequence row_open_s;
        $rose(row_strobe) && !row_column_select;
    endsequence
    sequence column_s;
        row_column_select ##1 (column_strobe != 4'h0);
    endsequence

    match_hold_a: assert property (
        tag_store_write |-> !match_valid_out) else $error("match valid during update");
    sram_select_a: assert property (
        !data_sram_select |-> tag_store_write) else $error("sram select dropped");
    byte_write_a: assert property (
        (data_sram_byte_write & ~be_reg) == 4'h0) else $error("stray byte write");
    tag_pulse_a: assert property (
        tag_store_write |=> !tag_store_write) else $error("tag write not a pulse");
    update_set_a: assert property (
        tag_store_write |-> tag_buffer_drive && pipeline_request && cache_buffer_direction)
        else $error("update outputs wrong");
    buffer_lane_a: assert property (
        (cache_buffer_byte_enable & ~be_reg) == 4'h0) else $error("stray buffer enable");
    row_column_a: assert property (
        row_open_s |=> column_s) else $error("row column order wrong");
    column_bank_a: assert property (
        column_strobe != 4'h0 |-> $onehot(column_strobe) && row_strobe && row_column_select)
        else $error("column strobe wrong");
    idle_column_a: assert property (
        cycle_idle |-> column_strobe == 4'h0) else $error("column strobe held in idle");
endmodule

bind ccd_cycle_control ccd_cycle_control_chk chk (.sys_clk, .srst, .cycle_start, .cycle_idle,
    .cycle_byte_en, .match_valid_out, .tag_store_write, .tag_buffer_drive, .pipeline_request,
    .data_sram_select, .data_sram_byte_write, .cache_buffer_direction,
    .cache_buffer_byte_enable, .row_strobe, .row_column_select, .column_strobe);

// ==== bench/tb_ccd_cycle_control.sv ====
// Purpose: directed bench for the cycle control block
// Assumes: 40 MHz sys_clk, srst held two cycles
// Notes:   each request is traced cycle by cycle until idle
`timescale 1ns/1ps
module tb_ccd_cycle_control;
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    logic       cycle_start = 1'b0;
    logic       cycle_memory = 1'b0;
    logic       cycle_write = 1'b0;
    logic       cycle_cacheable = 1'b0;
    logic [3:0] cycle_byte_en = 4'h0;
    logic [9:0] cycle_row = 10'h000;
    logic [1:0] cycle_bank = 2'h0;
    logic       page_mode_cfg = 1'b0;
    logic       cycle_idle, memory_ready, tag_match, match_valid_out, tag_store_write;
    logic       tag_buffer_drive, pipeline_request, data_sram_select;
    logic       cache_buffer_direction, row_strobe, row_column_select;
    logic [3:0] data_sram_byte_write, cache_buffer_byte_enable, column_strobe;
    logic [7:0] lat, rs_low, hv, tw, dir, cols, cbe, sbw, upd;
    int         n_fail = 0;
    int         n_compared = 0;

    // 25 ns period
    always #12.5 sys_clk = ~sys_clk;

    ccd_tag_model tags (.sys_clk, .srst, .cycle_start, .cycle_idle, .cycle_row,
        .tag_store_write, .tag_match);

    ccd_cycle_control uut (.sys_clk, .srst, .cycle_start, .cycle_memory, .cycle_write,
        .cycle_cacheable, .cycle_byte_en, .cycle_row, .cycle_bank, .cycle_idle,
        .memory_ready, .page_mode_cfg, .tag_match, .match_valid_out, .tag_store_write,
        .tag_buffer_drive, .pipeline_request, .data_sram_select, .data_sram_byte_write,
        .cache_buffer_direction, .cache_buffer_byte_enable, .row_strobe,
        .row_column_select, .column_strobe);

    task summarize;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one request, then trace outputs until the block is idle again
    task issue(input logic m, w, c, p, input logic [3:0] be, input logic [9:0] r,
               input logic [1:0] b);
        @(posedge sys_clk);
        cycle_start     <= 1'b1;
        cycle_memory    <= m;
        cycle_write     <= w;
        cycle_cacheable <= c;
        page_mode_cfg   <= p;
        cycle_byte_en   <= be;
        cycle_row       <= r;
        cycle_bank      <= b;
        @(posedge sys_clk);
        cycle_start <= 1'b0;
        {lat, rs_low, hv, tw, dir, cols, cbe, sbw, upd} = '0;
        for (int n = 1; n < 20; n++)
        begin
            #1;
            if (cycle_idle)
                break;
            if (memory_ready)
                lat = 8'(n);
            rs_low |= 8'(!row_strobe);
            hv     |= 8'(tag_match & match_valid_out);
            tw     |= 8'(tag_store_write);
            dir    |= 8'(cache_buffer_direction);
            cols   |= 8'(column_strobe);
            cbe    |= 8'(cache_buffer_byte_enable);
            sbw    |= 8'(data_sram_byte_write);
            upd    |= 8'({!data_sram_select, tag_buffer_drive, pipeline_request});
            @(posedge sys_clk);
        end
    endtask

    // cacheable read miss, normal mode: full dram cycle plus refill
    task read_miss;
        issue(1, 0, 1, 0, 4'h3, 10'h005, 2'h2);
        chk(lat, 8'h09);  // precharged access
        chk(cols, 8'h04); // bank two only
        chk(tw, 8'h01);   // tag rewritten
        chk(cbe, 8'h03);  // two lanes
        chk(hv, 8'h00);   // no false ready
        chk(dir, 8'h01);  // toward cache
        chk(upd, 8'h07);  // select low, tag buffer, pipeline
    endtask

    // same line again: zero wait hit from the cache
    task read_hit;
        issue(1, 0, 1, 0, 4'hf, 10'h005, 2'h1);
        chk(lat, 8'h00);  // no dram cycle
        chk(hv, 8'h01);   // hit ready
        chk(cbe, 8'h0f);  // all lanes
        chk(dir, 8'h00);  // toward cpu
        chk(upd, 8'h00);  // select stays high
    endtask

    // matching tag but uncacheable area: dram serves, row reopened
    task uncached_read;
        issue(1, 0, 0, 0, 4'hf, 10'h005, 2'h0);
        chk(lat, 8'h08);  // precharge again
        chk(cbe, 8'h00);  // not a hit
        chk(tw, 8'h00);   // no tag update
        chk(cols, 8'h01); // bank zero
        chk(hv, 8'h00);   // no zero-wait ready
        chk(upd, 8'h00);  // tag buffer closed
    endtask

    // page mode: open row reused across banks, new row precharges
    task page_run;
        issue(1, 0, 1, 1, 4'h3, 10'h009, 2'h0);
        chk(lat, 8'h09);    // row was closed
        issue(1, 1, 1, 1, 4'h6, 10'h009, 2'h3);
        chk(lat, 8'h04);    // row hit
        chk(rs_low, 8'h00); // other bank
        chk(cols, 8'h08);   // bank three
        chk(sbw, 8'h06);    // middle lanes
        chk(dir, 8'h01);    // write direction
        issue(1, 0, 1, 1, 4'hf, 10'h00c, 2'h1);
        chk(rs_low, 8'h01); // new row
        chk(lat, 8'h09);    // full sequence
    endtask

    // non-memory cycle ends at once without dram strobes
    task io_cycle;
        issue(0, 0, 0, 0, 4'hf, 10'h000, 2'h0);
        chk(lat, 8'h01);  // no column
        chk(cols, 8'h00); // strobes quiet
    endtask

    // mid-run reset closes the open page row and clears the tag store
    task reset_run;
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        #1;
        chk({row_strobe, row_column_select, data_sram_select, cycle_idle, column_strobe},
            8'h30);         // row closed by reset
        issue(1, 0, 1, 1, 4'h1, 10'h00c, 2'h0);
        chk(rs_low, 8'h01); // row reopened
        chk(lat, 8'h09);    // full sequence
    endtask

    // main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        read_miss();
        read_hit();
        uncached_read();
        page_run();
        io_cycle();
        reset_run();
        summarize();
    end

    // watchdog: the run needs well under a hundred requests' worth of cycles
    initial
    begin
        repeat (2000) @(posedge sys_clk);
        n_fail++;
        summarize();
    end
endmodule
